// ===== hw/cfg_load_pkg.sv
// Purpose: constants for the fast parallel configuration loader
// Assumes: system clock of 40 MHz (25 ns period)
// Notes:   cycle counts derive from the printed times
package cfg_load_pkg;

  localparam int unsigned SYS_CLK_PERIOD_NS = 25;

  // request low to load_complete / ready low, longest (ns)
  localparam int unsigned T_REQ_TO_LOW_NS   = 600;
  localparam int unsigned REQ_TO_LOW_CYC    =
    T_REQ_TO_LOW_NS / SYS_CLK_PERIOD_NS;

  // ready indication low, least time (us)
  localparam int unsigned T_READY_LOW_MIN_US = 268;
  localparam int unsigned READY_LOW_MIN_CYC  =
    (T_READY_LOW_MIN_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // request high to ready release, longest (us)
  localparam int unsigned T_REQ_TO_REL_US   = 1506;
  localparam int unsigned REQ_TO_REL_CYC    =
    T_REQ_TO_REL_US * 1000 / SYS_CLK_PERIOD_NS;

  // load_complete high to user mode, internal oscillator, least (us)
  localparam int unsigned T_INIT_MIN_US     = 175;
  localparam int unsigned INIT_MIN_CYC      =
    (T_INIT_MIN_US * 1000 + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;

  // user init clock enabled 4 max strobe periods after load_complete
  localparam int unsigned STROBE_MAX_PERIOD_NS = 10;
  localparam int unsigned UCLK_EN_PERIODS      = 4;
  localparam int unsigned UCLK_EN_CYC          =
    (UCLK_EN_PERIODS * STROBE_MAX_PERIOD_NS + SYS_CLK_PERIOD_NS - 1)
    / SYS_CLK_PERIOD_NS;
  localparam logic [15:0] UCLK_INIT_EDGES      = 16'h2180;

  // strobes per word, less one, while decompression or decryption is active
  localparam logic [1:0]  SLOW_RATIO_M1        = 2'h3;

  // bus width selection codes
  localparam logic [1:0]  WIDTH_8              = 2'h0;
  localparam logic [1:0]  WIDTH_16             = 2'h1;

  localparam logic [15:0] IMAGE_WORDS_DEF      = 16'h0010;

  typedef enum logic [2:0] {
    ST_HOLD, ST_WAIT_REL, ST_LOAD, ST_INIT_GAP, ST_INIT, ST_USER, ST_ERR
  } load_state_t;

endpackage : cfg_load_pkg

// ===== hw/fast_parallel_load.sv
// Purpose: device side of the fast parallel configuration load sequence
// Assumes: strobe clock, request, ready pin and data come from outside
//          the system clock domain and are sampled at 40 MHz
// Notes:   strobe edges are found by sampling, so the strobe must be
//          well below a quarter of the system clock
module fast_parallel_load
  import cfg_load_pkg::*;
#(
  parameter logic [15:0] P_READY_LOW_CYC = 16'(READY_LOW_MIN_CYC),
  parameter logic [15:0] P_INIT_CYC      = 16'(INIT_MIN_CYC),
  parameter logic [15:0] P_IMAGE_WORDS   = IMAGE_WORDS_DEF
) (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_config_req_n,
  input  wire logic        i_ready_n_in,
  output logic             o_ready_n_out,
  output logic             o_ready_n_oe,
  input  wire logic        i_config_strobe_clk,
  input  wire logic [31:0] i_data,
  input  wire logic [1:0]  i_bus_width,
  input  wire logic        i_decompress_en,
  input  wire logic        i_decrypt_en,
  input  wire logic        i_use_user_init_clock,
  input  wire logic        i_user_init_clock,
  output logic             o_load_complete,
  output logic             o_user_mode,
  output logic             o_load_error,
  output logic [31:0]      o_word,
  output logic             o_word_valid
);

  localparam int RDLY_MAX = 24;

  logic [1:0]  req_sync_ff;
  logic [1:0]  rdy_sync_ff;
  logic [2:0]  stb_sync_ff;
  logic [2:0]  uclk_sync_ff;
  logic [31:0] dat_meta_ff;
  logic [31:0] dat_ff;
  logic        req_prev_ff;
  load_state_t state_ff;
  load_state_t nxt_state;
  logic [15:0] cnt_ff;
  logic [15:0] nxt_cnt;
  logic [15:0] words_ff;
  logic [1:0]  beat_ff;
  logic        ready_oe_ff;
  logic        done_ff;
  logic        user_ff;
  logic        err_ff;
  logic [31:0] word_ff;
  logic        valid_ff;

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      req_sync_ff  <= 2'h0;
      rdy_sync_ff  <= 2'h0;
      stb_sync_ff  <= 3'h0;
      uclk_sync_ff <= 3'h0;
      dat_meta_ff  <= 32'h0;
      dat_ff       <= 32'h0;
      req_prev_ff  <= 1'b0;
    end else begin
      req_sync_ff  <= {req_sync_ff[0], i_config_req_n};
      rdy_sync_ff  <= {rdy_sync_ff[0], i_ready_n_in};
      stb_sync_ff  <= {stb_sync_ff[1:0], i_config_strobe_clk};
      uclk_sync_ff <= {uclk_sync_ff[1:0], i_user_init_clock};
      dat_meta_ff  <= i_data;
      dat_ff       <= dat_meta_ff;
      req_prev_ff  <= req_sync_ff[1];
    end
  end

  wire req_high   = req_sync_ff[1];
  wire req_fell   = req_prev_ff & ~req_high;
  wire ready_high = rdy_sync_ff[1];
  wire stb_rise   = stb_sync_ff[1] & ~stb_sync_ff[2];
  wire uclk_rise  = uclk_sync_ff[1] & ~uclk_sync_ff[2];
  // decompression or decryption slows the load to several strobes a word
  wire slow_mode  = i_decompress_en | i_decrypt_en;
  wire beat_last  = !slow_mode || (beat_ff == SLOW_RATIO_M1);
  wire take_word  = (state_ff == ST_LOAD) && stb_rise && beat_last;
  wire last_word  = take_word && (words_ff == P_IMAGE_WORDS - 16'h0001);
  wire hold_done  = cnt_ff >= P_READY_LOW_CYC;
  wire [31:0] word_masked =
    (i_bus_width == WIDTH_8)  ? {24'h0, dat_ff[7:0]}  :
    (i_bus_width == WIDTH_16) ? {16'h0, dat_ff[15:0]} : dat_ff;

  always_comb begin
    nxt_state = state_ff;
    nxt_cnt   = cnt_ff;
    if (req_fell) begin
      nxt_state = ST_HOLD;
      nxt_cnt   = 16'h0;
    end else begin
      unique case (state_ff)
        ST_HOLD: begin
          if (!hold_done) begin
            nxt_cnt = cnt_ff + 16'h0001;
          end else if (req_high) begin
            nxt_state = ST_WAIT_REL;
          end
        end
        ST_WAIT_REL: begin
          if (req_high && ready_high) begin
            nxt_state = ST_LOAD;
          end
        end
        ST_LOAD: begin
          // ready dragged low by someone else mid-load aborts the image
          if (!ready_high) begin
            nxt_state = ST_ERR;
          end else if (last_word) begin
            nxt_state = ST_INIT_GAP;
            nxt_cnt   = 16'h0;
          end
        end
        ST_INIT_GAP: begin
          if (!i_use_user_init_clock) begin
            nxt_state = ST_INIT;
          end else if (cnt_ff >= 16'(UCLK_EN_CYC) - 16'h0001) begin
            nxt_state = ST_INIT;
            nxt_cnt   = 16'h0;
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end
        ST_INIT: begin
          if (i_use_user_init_clock) begin
            if (cnt_ff == UCLK_INIT_EDGES) begin
              nxt_state = ST_USER;
            end else if (uclk_rise) begin
              nxt_cnt = cnt_ff + 16'h0001;
            end
          end else if (cnt_ff >= P_INIT_CYC) begin
            nxt_state = ST_USER;
          end else begin
            nxt_cnt = cnt_ff + 16'h0001;
          end
        end
        ST_USER: nxt_state = ST_USER;
        ST_ERR:  nxt_state = ST_ERR;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_ff <= ST_HOLD;
      cnt_ff   <= 16'h0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff   <= nxt_cnt;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      words_ff <= 16'h0;
      beat_ff  <= 2'h0;
      word_ff  <= 32'h0;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= take_word;
      if (state_ff != ST_LOAD) begin
        words_ff <= 16'h0;
        beat_ff  <= 2'h0;
      end else if (stb_rise) begin
        beat_ff <= beat_last ? 2'h0 : beat_ff + 2'h1;
        if (beat_last) begin
          words_ff <= words_ff + 16'h0001;
          word_ff  <= word_masked;
        end
      end
    end
  end

  // ready is open drain: only ever pulled low, released otherwise
  always_ff @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      ready_oe_ff <= 1'b1;
      done_ff     <= 1'b0;
      user_ff     <= 1'b0;
      err_ff      <= 1'b0;
    end else begin
      ready_oe_ff <= (nxt_state == ST_HOLD) || (nxt_state == ST_ERR);
      done_ff     <= (nxt_state == ST_INIT_GAP) || (nxt_state == ST_INIT)
                     || (nxt_state == ST_USER);
      user_ff     <= (nxt_state == ST_USER);
      err_ff      <= (nxt_state == ST_ERR);
    end
  end

  assign o_ready_n_out   = 1'b0;
  assign o_ready_n_oe    = ready_oe_ff;
  assign o_load_complete = done_ff;
  assign o_user_mode     = user_ff;
  assign o_load_error    = err_ff;
  assign o_word          = word_ff;
  assign o_word_valid    = valid_ff;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);

  chk_done_drop: assert property (
    req_fell |-> ##[1:RDLY_MAX] !o_load_complete)
    else $error("load_complete not low after request");
  chk_ready_drop: assert property (
    req_fell |-> ##[1:RDLY_MAX] o_ready_n_oe)
    else $error("ready not pulled low after request");
  chk_ready_min: assert property (
    (state_ff == ST_HOLD) && (nxt_state == ST_WAIT_REL)
      |-> cnt_ff >= P_READY_LOW_CYC)
    else $error("ready released too early");
  chk_ready_release: assert property (
    (state_ff == ST_HOLD) && hold_done && req_high && !req_fell
      |-> ##2 !o_ready_n_oe)
    else $error("ready not released after request high");
  chk_wait_both: assert property (
    (state_ff == ST_WAIT_REL) && !(req_high && ready_high)
      |=> state_ff != ST_LOAD)
    else $error("load entered before lines released");
  chk_word_edge: assert property (
    (state_ff == ST_LOAD) && stb_rise && !slow_mode && !req_fell
      |=> o_word_valid && (o_word == $past(word_masked)))
    else $error("word not captured on strobe edge");
  chk_slow_ratio: assert property (
    take_word && slow_mode |-> beat_ff == SLOW_RATIO_M1)
    else $error("slow mode word taken early");
  chk_done_image: assert property (
    $rose(o_load_complete) |-> $past(last_word))
    else $error("load_complete before whole image");
  chk_osc_init: assert property (
    $rose(o_user_mode) && !i_use_user_init_clock
      |-> $past(cnt_ff) >= P_INIT_CYC)
    else $error("user mode before init delay");
  chk_uclk_init: assert property (
    $rose(o_user_mode) && i_use_user_init_clock
      |-> $past(cnt_ff) == UCLK_INIT_EDGES)
    else $error("user mode before init clock count");
  chk_user_lines: assert property (
    o_user_mode |-> o_load_complete && !o_ready_n_oe)
    else $error("user mode with a line low");

endmodule : fast_parallel_load

// ===== sim/cfg_host_model.sv
// Purpose: behavioural configuration host for the parallel loader
// Assumes: ready wire has a pull-up; strobe period 200 ns
// Notes:   strobe stands low between words; data scrambled after each edge
module cfg_host_model (
  input  wire logic        i_ready_n,
  output logic             o_config_req_n,
  output logic             o_config_strobe_clk,
  output logic             o_ready_hold,
  output logic [31:0]      o_data
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_config_req_n      = 1'b1;
    o_config_strobe_clk = 1'b0;
    o_ready_hold        = 1'b0;
    o_data              = 32'h0000_0000;
  end
  task automatic pulse_req(input int unsigned low_ns);
    #1;
    o_config_req_n = 1'b0;
    #(low_ns < 2000 ? 2000 : low_ns);
    o_config_req_n = 1'b1;
  endtask : pulse_req
  // holding ready low delays the load, or marks a fault mid-load
  task automatic hold_ready(input logic v);
    #1;
    o_ready_hold = v;
  endtask : hold_ready
  task automatic wait_ready();
    wait (i_ready_n === 1'b1);
    #2000;
    #1;
  endtask : wait_ready
  // a host that ignores ready just waits a fixed gap after request high
  task automatic wait_after_req(input int unsigned gap_ns);
    #(gap_ns);
  endtask : wait_after_req
  task automatic send_word(input logic [31:0] w);
    o_data = w;
    #100;
    o_config_strobe_clk = 1'b1;
    // held well past the edge, then scrambled so a late sample shows
    #75;
    o_data = ~w;
    #25;
    o_config_strobe_clk = 1'b0;
  endtask : send_word
endmodule : cfg_host_model

// ===== sim/parallel_config_load_sequence_bench.sv
// Purpose: self-checking bench for the fast parallel loader
// Assumes: shortened ready hold, init and image counts
// Notes:   host model drives request, strobe, data and ready hold
module parallel_config_load_sequence_bench;
  import cfg_load_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int HOLD_C = 200;
  localparam int INIT_C = 20;
  localparam int WORDS  = 4;
  logic        sys_clk, rstn, uclk, uclk_run, req_n, ready_n, ready_out;
  logic        ready_oe, hold, strobe, dcmp, dcry, use_uclk, lc, um, lerr;
  logic        wvalid;
  logic [1:0]  width;
  logic [31:0] data, word, last_word;
  int          errors, checks_done, nwords, lc_age;
  // open-drain ready wire with pull-up
  assign ready_n = ~((ready_oe & ~ready_out) | hold);
  fast_parallel_load #(.P_READY_LOW_CYC(16'(HOLD_C)),
    .P_INIT_CYC(16'(INIT_C)), .P_IMAGE_WORDS(16'(WORDS))) dut_u (
    .i_sys_clk(sys_clk), .i_rstn(rstn), .i_config_req_n(req_n),
    .i_ready_n_in(ready_n), .o_ready_n_out(ready_out),
    .o_ready_n_oe(ready_oe), .i_config_strobe_clk(strobe), .i_data(data),
    .i_bus_width(width), .i_decompress_en(dcmp), .i_decrypt_en(dcry),
    .i_use_user_init_clock(use_uclk), .i_user_init_clock(uclk),
    .o_load_complete(lc), .o_user_mode(um), .o_load_error(lerr),
    .o_word(word), .o_word_valid(wvalid));
  cfg_host_model host_u (.i_ready_n(ready_n), .o_config_req_n(req_n),
    .o_config_strobe_clk(strobe), .o_ready_hold(hold), .o_data(data));
  initial begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end
  // under 10 MHz so every edge is seen by the sampler
  initial begin
    uclk = 1'b0;
    forever #60 uclk = uclk_run & ~uclk;
  end
  always @(posedge sys_clk) if (wvalid === 1'b1) begin
    nwords    <= nwords + 1;
    last_word <= word;
  end
  // cycles since load_complete rose, for the init delay check
  always @(posedge sys_clk) lc_age <= (lc === 1'b1) ? lc_age + 1 : 0;
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      errors++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : check
  // reset acts as a fresh request: ready held for the minimum time
  task automatic t_reset();
    int n;
    n = 0;
    while (ready_oe !== 1'b0 && n < HOLD_C + 40) begin
      @(posedge sys_clk);
      n++;
    end
    check(n >= HOLD_C && n <= HOLD_C + 8, "power-on hold");
    $display("test reset done");
  endtask : t_reset
  task automatic t_load(input logic [1:0] w, input bit hld, input int per);
    int          n;
    int          base;
    logic [31:0] d;
    logic [31:0] exp;
    @(posedge sys_clk) width <= w;
    host_u.hold_ready(hld);
    fork
      host_u.pulse_req(2000);
    join_none
    n = 0;
    while (!(ready_oe === 1'b1 && lc === 1'b0 && lerr === 1'b0)
           && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check(n <= 24, "ready or done late");
    // a few cycles short of the end of the minimum hold
    repeat (HOLD_C - 4) @(posedge sys_clk);
    check(ready_oe === 1'b1, "ready released early");
    wait (req_n === 1'b1);
    n = 0;
    while (ready_oe !== 1'b0 && n < 40) begin
      @(posedge sys_clk);
      n++;
    end
    check(n <= 8, "ready not released");
    base = nwords;
    if (hld) begin
      host_u.send_word(32'hFFFF_FFFF);
      repeat (6) @(posedge sys_clk);
      check(nwords == base, "word taken while held");
      host_u.hold_ready(1'b0);
    end
    host_u.wait_ready();
    for (int k = 0; k < WORDS; k++) begin
      d   = 32'h93A5_C601 + 32'(k);
      exp = w == WIDTH_8 ? {24'h00_0000, d[7:0]} :
            w == WIDTH_16 ? {16'h0000, d[15:0]} : d;
      check(lc === 1'b0, "done before image end");
      repeat (per - 1) host_u.send_word(~d);
      host_u.send_word(d);
      repeat (4) @(posedge sys_clk);
      check(nwords == base + k + 1 && last_word === exp, "bad word");
    end
    repeat (8) @(posedge sys_clk);
    check(lc === 1'b1, "done not raised");
    $display("test load done");
  endtask : t_load
  task automatic t_osc();
    int n;
    n = 0;
    while (um !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    check(lc_age >= INIT_C && lc_age <= INIT_C + 10, "init time");
    check(req_n === 1'b1 && ready_n === 1'b1 && lc === 1'b1, "user lines");
    $display("test osc init done");
  endtask : t_osc
  task automatic t_error();
    host_u.pulse_req(2000);
    host_u.wait_after_req(8000);
    host_u.send_word(32'h5A5A_0F0F);
    host_u.hold_ready(1'b1);
    repeat (8) @(posedge sys_clk);
    check(lerr === 1'b1 && lc === 1'b0, "fault not flagged");
    host_u.hold_ready(1'b0);
    repeat (8) @(posedge sys_clk);
    check(lerr === 1'b1 && ready_oe === 1'b1, "fault not held");
    $display("test error done");
  endtask : t_error
  task automatic t_uclk();
    int n;
    @(posedge sys_clk) use_uclk <= 1'b1;
    t_load(2'h2, 1'b0, 1);
    uclk_run = 1'b1;
    n        = 0;
    while (um !== 1'b1 && n < 42000) begin
      @(posedge sys_clk);
      n++;
    end
    check(n >= 41160 && n <= 41190, "user clock init");
    uclk_run = 1'b0;
    $display("test user clock done");
  endtask : t_uclk
  task automatic test_done();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : test_done
  initial begin
    #1_300_000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    test_done();
  end
  initial begin
    {rstn, dcmp, dcry, use_uclk, uclk_run} = 5'h00;
    {width, errors, checks_done}          = '0;
    repeat (20) @(posedge sys_clk);
    check(ready_oe === 1'b1 && lc === 1'b0 && um === 1'b0, "reset state");
    rstn <= 1'b1;
    t_reset();
    t_load(WIDTH_8, 1'b0, 1);
    t_osc();
    t_load(WIDTH_16, 1'b1, 1);
    t_osc();
    @(posedge sys_clk) dcmp <= 1'b1;
    t_load(2'h2, 1'b0, 4);
    t_osc();
    @(posedge sys_clk) {dcmp, dcry} <= 2'h1;
    t_load(2'h2, 1'b0, 4);
    t_osc();
    @(posedge sys_clk) dcry <= 1'b0;
    t_error();
    t_uclk();
    test_done();
  end
endmodule : parallel_config_load_sequence_bench
